// ===== logic/pll_soft_freq_code_map.vh
`ifndef PLL_SOFT_FREQ_CODE_MAP_VH
`define PLL_SOFT_FREQ_CODE_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_DYN_MSB      8'h09
`define ADDR_DYN_SET1     8'h0A
`define ADDR_DYN_SET2     8'h0B
`define ADDR_DYN_SET3     8'h0C
`define ADDR_WD_CTRL      8'h0D
`define ADDR_PROC_N_LOW   8'h0E
`define ADDR_PROC_NM      8'h0F
`define ADDR_SREF_N_LOW   8'h10
`define ADDR_WD_REST_LOW  8'h11
`define ADDR_MODE         8'h12
`define ADDR_SOFT_CODE    8'h13
`define ADDR_STATUS       8'h14
`define REG_FIRST         8'h09
`define REG_COUNT         11
`define REG_LAST_IDX      4'hA

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define REG_RESET         8'h00
`define WD_CTRL_RESET     8'h20
`define READ_UNMAPPED     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_SREF_MSB     7
`define MODE_OVERRIDE     6
`define MODE_DYN_EN       5
`define MODE_EXT_RST_EN   4
`define MODE_SREF_PROG    3
`define MODE_PROC_PROG    2
`define MODE_AUTO_REC     1
`define MODE_REST_MSB     0
`define WD_REC_FROM_N     7
`define WD_RESET_ONLY     6
`define WD_ENABLE         0
`define DYN1_MSB          5
`define DYN2_MSB          6
`define DYN3_MSB          7
`define PROC_N_MSB        7
`define SOFT_CODE_HI      3

// ----------------------------------------------------------------------
// Dynamic pin codes and shared output routes
// ----------------------------------------------------------------------
`define DYN_ORIGINAL      2'h0
`define DYN_SET1          2'h1
`define DYN_SET2          2'h2
`define DYN_SET3          2'h3
`define ROUTE_LINK        2'h0
`define ROUTE_DOT96       2'h1
`define ROUTE_SATA        2'h2
`define SHARED_SATA       1'b0
`define SHARED_SREF       1'b1
`define PLAT_LINK_SATA    2'h0
`define PLAT_DOT_SATA     2'h1
`define PLAT_LINK_SREF    2'h2
`define PLAT_SATA_SREF    2'h3

// ----------------------------------------------------------------------
// Management port bit counting
// ----------------------------------------------------------------------
`define BITS_PER_BYTE     4'h8

`endif

// ===== logic/n_value_select.v
`timescale 1ns/1ps
`default_nettype none
`include "pll_soft_freq_code_map.vh"

module n_value_select
  #(parameter NW = 9)
  (
  input  wire          dyn_en,
  input  wire [1:0]    dyn_pins,
  input  wire [NW-1:0] base_n,
  input  wire [NW-1:0] set_one,
  input  wire [NW-1:0] set_two,
  input  wire [NW-1:0] set_three,
  output reg  [NW-1:0] n_out
  );

  // Dynamic pins pick the working N, else the base value
  always @*
  begin
    n_out = base_n;
    if (dyn_en)
    begin
      case (dyn_pins)
        `DYN_ORIGINAL: n_out = base_n;
        `DYN_SET1:     n_out = set_one;
        `DYN_SET2:     n_out = set_two;
        `DYN_SET3:     n_out = set_three;
        default:       n_out = base_n;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== logic/smbus_byte_port.v
`timescale 1ns/1ps
`default_nettype none
`include "pll_soft_freq_code_map.vh"

module smbus_byte_port
  #(parameter [6:0] DEV_ADDR = 7'h5A)
  (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg        wr_stb,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        xfer_done,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data
  );

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_CMD  = 3'h2;
  localparam [2:0] S_WDAT = 3'h3;
  localparam [2:0] S_ACK  = 3'h4;
  localparam [2:0] S_RDAT = 3'h5;
  localparam [2:0] S_RACK = 3'h6;

  reg       scl_q;
  reg       sda_q;
  reg [2:0] state_q;
  reg [2:0] after_ack_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg       host_ack_q;

  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c  = scl_in & scl_q & ~sda_q & sda_in;
  wire rise_c  = scl_in & ~scl_q;
  wire fall_c  = ~scl_in & scl_q;

  assign rd_addr = ptr_q;

  // ----------------------------------------------------------------------
  // Byte engine: address, command, write data, read data
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      state_q     <= S_IDLE;
      after_ack_q <= S_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      ptr_q       <= 8'h00;
      host_ack_q  <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      wr_stb      <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
      xfer_done   <= 1'b0;
    end
    else
    begin
      scl_q     <= scl_in;
      sda_q     <= sda_in;
      wr_stb    <= 1'b0;
      xfer_done <= 1'b0;
      if (start_c)
      begin
        state_q <= S_ADDR;
        cnt_q   <= 4'h0;
        sda_oe  <= 1'b0;
      end
      else if (stop_c)
      begin
        // Whole transaction over: commit point
        state_q   <= S_IDLE;
        sda_oe    <= 1'b0;
        xfer_done <= (state_q != S_IDLE);
      end
      else
      begin
        case (state_q)
          S_ADDR, S_CMD, S_WDAT:
          begin
            if (rise_c && cnt_q != `BITS_PER_BYTE)
            begin
              sh_q  <= {sh_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (fall_c && cnt_q == `BITS_PER_BYTE)
            begin
              cnt_q   <= 4'h0;
              sda_out <= 1'b0;
              sda_oe  <= 1'b1;
              state_q <= S_ACK;
              if (state_q == S_ADDR)
              begin
                if (sh_q[7:1] != DEV_ADDR)
                begin
                  sda_oe  <= 1'b0;
                  state_q <= S_IDLE;
                end
                after_ack_q <= sh_q[0] ? S_RDAT : S_CMD;
                if (!sh_q[0])
                  after_ack_q <= S_CMD;
              end
              else if (state_q == S_CMD)
              begin
                ptr_q       <= sh_q;
                after_ack_q <= S_WDAT;
              end
              else
              begin
                wr_stb      <= 1'b1;
                wr_addr     <= ptr_q;
                wr_data     <= sh_q;
                ptr_q       <= ptr_q + 8'h01;
                after_ack_q <= S_WDAT;
              end
            end
          end
          S_ACK:
          begin
            if (fall_c)
            begin
              state_q <= after_ack_q;
              if (after_ack_q == S_RDAT)
              begin
                sda_out <= rd_data[7];
                sh_q    <= {rd_data[6:0], 1'b0};
                cnt_q   <= 4'h1;
              end
              else
                sda_oe <= 1'b0;
            end
          end
          S_RDAT:
          begin
            if (fall_c)
            begin
              if (cnt_q == `BITS_PER_BYTE)
              begin
                sda_oe  <= 1'b0;
                state_q <= S_RACK;
              end
              else
              begin
                sda_out <= sh_q[7];
                sh_q    <= {sh_q[6:0], 1'b0};
                cnt_q   <= cnt_q + 4'h1;
              end
            end
          end
          S_RACK:
          begin
            if (rise_c)
            begin
              host_ack_q <= ~sda_in;
              if (!sda_in)
                ptr_q <= ptr_q + 8'h01;
            end
            else if (fall_c)
            begin
              if (host_ack_q)
              begin
                sda_out <= rd_data[7];
                sda_oe  <= 1'b1;
                sh_q    <= {rd_data[6:0], 1'b0};
                cnt_q   <= 4'h1;
                state_q <= S_RDAT;
              end
              else
                state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/pll_frequency_select_control.v
// Notes on behaviour
// - Serial-reference N is nine bits: low byte plus mode bit 7; resets zero.
// - Mode bit 6 picks processor code: zero straps, one software code.
// - Mode bit 5 enables dynamic frequency; then dynamic pins pick N.
// - Mode bit 4 gates the external active-low reset input; default off.
// - Mode bit 3 makes the serial-reference synthesizer use programmed N.
// - Mode bit 2 makes the processor synthesizer use programmed N and M.
// - Mode bit 1 picks recovery supply: zero manual, one automatic.
// - Recovery N is nine bits: whole byte plus mode bit 0; RW, zero.
// - Platform strap routes shared outputs: link/SATA, video/SATA, link/ref, SATA/ref.
// - Dynamic pins: 00 original, 01 first set, 10 second, 11 third.
// - A dynamic pin change in dynamic mode loads the newly selected N.
// - Programmed output equals gear constant times N over M, gear from code.
// - Serial-reference M is fixed internally; only its N is programmable.
// - Processor N nine bits, M seven bits, serial-reference N nine bits.
// - Watchdog expiry in programmed mode applies auto, manual, strap or none.
// - No recovery is applied to the serial-reference programmed frequency.
// - Software code is four bits, used only while override is set.
// - Enabling the watchdog latches current M and N for later reload.
// - Manual recovery restores recovery N with the internally latched M.
`timescale 1ns/1ps
`default_nettype none
`include "pll_soft_freq_code_map.vh"

module pll_frequency_select_control
  #(parameter [6:0] DEV_ADDR     = 7'h5A,
    parameter [6:0] SREF_M_FIXED = 7'h01,
    parameter       NW           = 9,
    parameter       MW           = 7)
  (
  input  wire          CORE_CLK,
  input  wire          RST_N,
  input  wire          SCL_IN,
  input  wire          SDA_IN,
  output wire          SDA_OUT,
  output wire          SDA_OE,
  input  wire [4:0]    STRAP_FREQ_CODE_PINS,
  input  wire [1:0]    PLATFORM_STRAP,
  input  wire [1:0]    DYN_FREQ_PINS,
  input  wire          WD_EXPIRE,
  output reg  [NW-1:0] PROC_SYNTH_N,
  output reg  [MW-1:0] PROC_SYNTH_M,
  output reg           PROC_PROG_EN,
  output reg  [4:0]    PROC_FREQ_CODE,
  output reg           PROC_N_LOAD,
  output reg           DYN_FREQ_ACTIVE,
  output reg  [NW-1:0] SERIAL_REF_SYNTH_N,
  output reg  [MW-1:0] SERIAL_REF_SYNTH_M,
  output reg           SERIAL_REF_PROG_EN,
  output reg           EXT_RESET_IN_EN,
  output reg           WD_RESET_ONLY,
  output reg  [1:0]    SHARED_A_ROUTE,
  output reg           SHARED_B_ROUTE
  );

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg  [7:0]    shadow_q [0:`REG_COUNT-1];
  reg  [7:0]    act_q    [0:`REG_COUNT-1];
  reg  [NW-1:0] latch_n_q;
  reg  [MW-1:0] latch_m_q;
  reg           wd_enable_bit_q;
  reg  [1:0]    dyn_pins_q;
  reg  [4:0]    strap_code_q;
  reg  [1:0]    platform_q;
  reg           straps_taken_q;
  integer       i;

  wire          wr_stb;
  wire [7:0]    wr_addr;
  wire [7:0]    wr_data;
  wire          xfer_done;
  wire [7:0]    rd_addr;
  reg  [7:0]    rd_data;
  wire [NW-1:0] dyn_n;

  // Map a bus offset onto a storage slot
  function [3:0] slot;
    input [7:0] addr;
    reg   [7:0] diff;
    begin
      diff = addr - `REG_FIRST;
      slot = diff[3:0];
    end
  endfunction

  // True for offsets backed by storage
  function in_map;
    input [7:0] addr;
    begin
      in_map = (addr >= `REG_FIRST) && (addr <= `ADDR_SOFT_CODE);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Field views of the active registers
  // ----------------------------------------------------------------------
  wire [7:0] mode_a     = act_q[slot(`ADDR_MODE)];
  wire [7:0] wd_ctrl_a  = act_q[slot(`ADDR_WD_CTRL)];
  wire [7:0] pnm_a      = act_q[slot(`ADDR_PROC_NM)];
  wire [7:0] dyn_msb_a  = act_q[slot(`ADDR_DYN_MSB)];
  wire [NW-1:0] proc_n_a = {pnm_a[`PROC_N_MSB], act_q[slot(`ADDR_PROC_N_LOW)]};
  wire [MW-1:0] proc_m_a = pnm_a[MW-1:0];
  wire [NW-1:0] sref_n_a = {mode_a[`MODE_SREF_MSB], act_q[slot(`ADDR_SREF_N_LOW)]};
  wire [NW-1:0] rest_n_a = {mode_a[`MODE_REST_MSB], act_q[slot(`ADDR_WD_REST_LOW)]};
  wire [NW-1:0] set1_a   = {dyn_msb_a[`DYN1_MSB], act_q[slot(`ADDR_DYN_SET1)]};
  wire [NW-1:0] set2_a   = {dyn_msb_a[`DYN2_MSB], act_q[slot(`ADDR_DYN_SET2)]};
  wire [NW-1:0] set3_a   = {dyn_msb_a[`DYN3_MSB], act_q[slot(`ADDR_DYN_SET3)]};
  wire [3:0]    soft_a   = act_q[slot(`ADDR_SOFT_CODE)][`SOFT_CODE_HI:0];
  wire          dyn_en_a = mode_a[`MODE_DYN_EN];
  wire          wd_enable_bit_a  = wd_ctrl_a[`WD_ENABLE];

  // Watchdog expiry acts only in programmed processor mode with watchdog on
  wire rec_go      = WD_EXPIRE & mode_a[`MODE_PROC_PROG] & wd_enable_bit_a
                     & ~wd_ctrl_a[`WD_RESET_ONLY];
  wire rec_strap   = rec_go & ~wd_ctrl_a[`WD_REC_FROM_N];
  wire rec_auto    = rec_go & wd_ctrl_a[`WD_REC_FROM_N] & mode_a[`MODE_AUTO_REC];
  wire rec_manual  = rec_go & wd_ctrl_a[`WD_REC_FROM_N] & ~mode_a[`MODE_AUTO_REC];
  wire [NW-1:0] rec_n = rec_auto ? latch_n_q : rest_n_a;
  wire [7:0]    mode_strap = mode_a & ~((8'h01 << `MODE_PROC_PROG)
                             | (8'h01 << `MODE_OVERRIDE) | (8'h01 << `MODE_DYN_EN));

  // ----------------------------------------------------------------------
  // Management bus port
  // ----------------------------------------------------------------------
  smbus_byte_port
    #(.DEV_ADDR (DEV_ADDR))
  u_port
    (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .scl_in    (SCL_IN),
    .sda_in    (SDA_IN),
    .sda_out   (SDA_OUT),
    .sda_oe    (SDA_OE),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .xfer_done (xfer_done),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
    );

  // ----------------------------------------------------------------------
  // Dynamic N selection
  // ----------------------------------------------------------------------
  n_value_select
    #(.NW (NW))
  u_nsel
    (
    .dyn_en    (dyn_en_a),
    .dyn_pins  (DYN_FREQ_PINS),
    .base_n    (proc_n_a),
    .set_one   (set1_a),
    .set_two   (set2_a),
    .set_three (set3_a),
    .n_out     (dyn_n)
    );

  // ----------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------
  // Written values read back; status shows straps and live mode
  always @*
  begin
    rd_data = `READ_UNMAPPED;
    if (in_map(rd_addr))
      rd_data = shadow_q[slot(rd_addr)];
    else if (rd_addr == `ADDR_STATUS)
      rd_data = {strap_code_q, platform_q, DYN_FREQ_ACTIVE};
  end

  // ----------------------------------------------------------------------
  // Shadow and active registers
  // ----------------------------------------------------------------------
  // Writes land in shadow; whole set goes live at transaction end
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      for (i = 0; i < `REG_COUNT; i = i + 1)
      begin
        shadow_q[i] <= `REG_RESET;
        act_q[i]    <= `REG_RESET;
      end
      shadow_q[slot(`ADDR_WD_CTRL)] <= `WD_CTRL_RESET;
      act_q[slot(`ADDR_WD_CTRL)]    <= `WD_CTRL_RESET;
    end
    else
    begin
      if (wr_stb && in_map(wr_addr))
        shadow_q[slot(wr_addr)] <= wr_data;
      if (xfer_done)
      begin
        for (i = 0; i < `REG_COUNT; i = i + 1)
          act_q[i] <= shadow_q[i];
      end
      // Recovery overrides both copies so a later commit keeps it
      if (rec_strap)
      begin
        act_q[slot(`ADDR_MODE)]    <= mode_strap;
        shadow_q[slot(`ADDR_MODE)] <= mode_strap;
      end
      else if (rec_auto || rec_manual)
      begin
        act_q[slot(`ADDR_PROC_N_LOW)]    <= rec_n[7:0];
        shadow_q[slot(`ADDR_PROC_N_LOW)] <= rec_n[7:0];
        act_q[slot(`ADDR_PROC_NM)]       <= {rec_n[NW-1], latch_m_q};
        shadow_q[slot(`ADDR_PROC_NM)]    <= {rec_n[NW-1], latch_m_q};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog recovery latch and strap capture
  // ----------------------------------------------------------------------
  // Rising watchdog enable snapshots the programmed processor N and M
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      latch_n_q      <= {NW{1'b0}};
      latch_m_q      <= {MW{1'b0}};
      wd_enable_bit_q        <= 1'b0;
      dyn_pins_q     <= `DYN_ORIGINAL;
      strap_code_q   <= 5'h00;
      platform_q     <= `PLAT_LINK_SATA;
      straps_taken_q <= 1'b0;
    end
    else
    begin
      wd_enable_bit_q    <= wd_enable_bit_a;
      dyn_pins_q <= DYN_FREQ_PINS;
      if (wd_enable_bit_a && !wd_enable_bit_q)
      begin
        latch_n_q <= proc_n_a;
        latch_m_q <= proc_m_a;
      end
      if (!straps_taken_q)
      begin
        strap_code_q   <= STRAP_FREQ_CODE_PINS;
        platform_q     <= PLATFORM_STRAP;
        straps_taken_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Synthesizer control outputs
  // ----------------------------------------------------------------------
  // All outputs registered, from the active settings, the captured straps and the live dynamic pins
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      PROC_SYNTH_N       <= {NW{1'b0}};
      PROC_SYNTH_M       <= {MW{1'b0}};
      PROC_PROG_EN       <= 1'b0;
      PROC_FREQ_CODE     <= 5'h00;
      PROC_N_LOAD        <= 1'b0;
      DYN_FREQ_ACTIVE    <= 1'b0;
      SERIAL_REF_SYNTH_N <= {NW{1'b0}};
      SERIAL_REF_SYNTH_M <= {MW{1'b0}};
      SERIAL_REF_PROG_EN <= 1'b0;
      EXT_RESET_IN_EN    <= 1'b0;
      WD_RESET_ONLY      <= 1'b0;
      SHARED_A_ROUTE     <= `ROUTE_LINK;
      SHARED_B_ROUTE     <= `SHARED_SATA;
    end
    else
    begin
      PROC_SYNTH_N    <= dyn_n;
      PROC_SYNTH_M    <= proc_m_a;
      PROC_PROG_EN    <= mode_a[`MODE_PROC_PROG];
      DYN_FREQ_ACTIVE <= dyn_en_a;
      PROC_N_LOAD     <= dyn_en_a && (DYN_FREQ_PINS != dyn_pins_q);
      // Gear selection code: straps or software code
      if (mode_a[`MODE_OVERRIDE])
        PROC_FREQ_CODE <= {strap_code_q[4], soft_a};
      else
        PROC_FREQ_CODE <= strap_code_q;
      SERIAL_REF_SYNTH_N <= sref_n_a;
      SERIAL_REF_SYNTH_M <= SREF_M_FIXED;
      SERIAL_REF_PROG_EN <= mode_a[`MODE_SREF_PROG];
      EXT_RESET_IN_EN    <= mode_a[`MODE_EXT_RST_EN];
      WD_RESET_ONLY      <= wd_ctrl_a[`WD_RESET_ONLY];
      // Shared output routing from platform strap
      case (platform_q)
        `PLAT_LINK_SATA:
        begin
          SHARED_A_ROUTE <= `ROUTE_LINK;
          SHARED_B_ROUTE <= `SHARED_SATA;
        end
        `PLAT_DOT_SATA:
        begin
          SHARED_A_ROUTE <= `ROUTE_DOT96;
          SHARED_B_ROUTE <= `SHARED_SATA;
        end
        `PLAT_LINK_SREF:
        begin
          SHARED_A_ROUTE <= `ROUTE_LINK;
          SHARED_B_ROUTE <= `SHARED_SREF;
        end
        `PLAT_SATA_SREF:
        begin
          SHARED_A_ROUTE <= `ROUTE_SATA;
          SHARED_B_ROUTE <= `SHARED_SREF;
        end
        default:
        begin
          SHARED_A_ROUTE <= `ROUTE_LINK;
          SHARED_B_ROUTE <= `SHARED_SATA;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== dv/soft_freq_code_chk.sv
`timescale 1ns/1ps
`default_nettype none
module soft_freq_code_chk
  #(parameter       NW           = 9,
    parameter       MW           = 7,
    parameter [6:0] SREF_M_FIXED = 7'h01)
  (
  input wire logic          CORE_CLK,
  input wire logic          RST_N,
  input wire logic [1:0]    DYN_FREQ_PINS,
  input wire logic          WD_EXPIRE,
  input wire logic [NW-1:0] PROC_SYNTH_N,
  input wire logic [MW-1:0] PROC_SYNTH_M,
  input wire logic          PROC_N_LOAD,
  input wire logic          DYN_FREQ_ACTIVE,
  input wire logic [NW-1:0] SERIAL_REF_SYNTH_N,
  input wire logic [MW-1:0] SERIAL_REF_SYNTH_M,
  input wire logic          WD_RESET_ONLY,
  input wire logic [1:0]    SHARED_A_ROUTE,
  input wire logic          SHARED_B_ROUTE
  );
  // ------------------------------------------------------------
  // Output relations
  // ------------------------------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  AST_DYN_LOAD: assert property (DYN_FREQ_ACTIVE && $changed(DYN_FREQ_PINS) |=> PROC_N_LOAD)
    else $error("pin change without load pulse");
  AST_LOAD_CAUSE: assert property (PROC_N_LOAD |-> $past(DYN_FREQ_PINS) != $past(DYN_FREQ_PINS, 2))
    else $error("load pulse without pin change");
  AST_LOAD_MODE: assert property (PROC_N_LOAD |-> DYN_FREQ_ACTIVE || $past(DYN_FREQ_ACTIVE))
    else $error("load pulse outside dynamic mode");
  AST_DYN_M: assert property (DYN_FREQ_ACTIVE && $changed(DYN_FREQ_PINS) |=> $stable(PROC_SYNTH_M)[*2])
    else $error("pin change moved the divisor");
  AST_SREF_M: assert property ($past(RST_N) |=> SERIAL_REF_SYNTH_M == SREF_M_FIXED)
    else $error("serial reference divisor not fixed");
  AST_SREF_WD: assert property (WD_EXPIRE |=> $stable(SERIAL_REF_SYNTH_N)[*2])
    else $error("expiry touched serial reference");
  AST_RESET_ONLY: assert property (WD_EXPIRE && WD_RESET_ONLY
    |=> ($stable(PROC_SYNTH_N) && $stable(PROC_SYNTH_M))[*2])
    else $error("reset-only expiry changed N or M");
  AST_ROUTE: assert property (SHARED_A_ROUTE != 2'h3 &&
    !(SHARED_B_ROUTE ? SHARED_A_ROUTE == 2'h1 : SHARED_A_ROUTE == 2'h2))
    else $error("illegal shared output route pair");
endmodule
bind pll_frequency_select_control soft_freq_code_chk #(.NW(NW), .MW(MW), .SREF_M_FIXED(SREF_M_FIXED))
  i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .DYN_FREQ_PINS(DYN_FREQ_PINS),
  .WD_EXPIRE(WD_EXPIRE), .PROC_SYNTH_N(PROC_SYNTH_N), .PROC_SYNTH_M(PROC_SYNTH_M),
  .PROC_N_LOAD(PROC_N_LOAD), .DYN_FREQ_ACTIVE(DYN_FREQ_ACTIVE),
  .SERIAL_REF_SYNTH_N(SERIAL_REF_SYNTH_N), .SERIAL_REF_SYNTH_M(SERIAL_REF_SYNTH_M),
  .WD_RESET_ONLY(WD_RESET_ONLY), .SHARED_A_ROUTE(SHARED_A_ROUTE),
  .SHARED_B_ROUTE(SHARED_B_ROUTE));
`default_nettype wire

// ===== dv/smb_host.sv
`timescale 1ns/1ps
`default_nettype none
module smb_host
  #(parameter logic [6:0] DEV = 7'h5A)
  (
  input  wire logic clk,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda
  );
  logic ack;
  // ------------------------------------------------------------
  // Bus phases, each held four clocks
  // ------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    ack = 1'b0;
  end
  task hold;
    repeat (4) @(negedge clk);
  endtask
  // Data set while clock low, sampled while high
  task cbit(input logic b, output logic r);
    sda = b;
    hold;
    scl = 1'b1;
    hold;
    r = sda_in;
    scl = 1'b0;
    hold;
  endtask
  // Byte out, MSB first; ack slot released
  task xfer(input logic [7:0] d, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      cbit(d[i], r[i]);
    cbit(1'b1, a);
    ack = !a;
  endtask
  task start;
    sda = 1'b1;
    hold;
    scl = 1'b1;
    hold;
    sda = 1'b0;
    hold;
    scl = 1'b0;
    hold;
  endtask
  task stop;
    sda = 1'b0;
    hold;
    scl = 1'b1;
    hold;
    sda = 1'b1;
    hold;
  endtask
  // Pointer then data bytes, auto-increment
  task wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    start;
    xfer({DEV, 1'b0}, r);
    xfer(a, r);
    foreach (d[i])
      xfer(d[i], r);
    stop;
  endtask
  // Single byte read, last byte not acked
  task rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] r;
    start;
    xfer({DEV, 1'b0}, r);
    xfer(a, r);
    start;
    xfer({DEV, 1'b1}, r);
    xfer(8'hFF, v);
    stop;
  endtask
  task probe(input logic [6:0] dv);
    logic [7:0] r;
    start;
    xfer({dv, 1'b0}, r);
    stop;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] MFIX = 7'h05;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] plat = 2'h0;
  logic [1:0] dyn = 2'h0;
  logic       wd = 1'b0;
  logic [7:0] rdv;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cyc = 0;
  wire        scl, sda_h, sda_o, sda_oe, load, prog, dact, sen, xen, ronly, b_rt;
  wire [8:0]  n, sn;
  wire [6:0]  m, sm;
  wire [4:0]  code;
  wire [1:0]  a_rt;
  wire        sda_w = sda_h & (sda_oe ? sda_o : 1'b1);
  logic [8:0] dn [4] = '{9'h1A5, 9'h111, 9'h022, 9'h133};
  logic [2:0] rt [4] = '{3'h0, 3'h2, 3'h1, 3'h5};
  pll_frequency_select_control #(.SREF_M_FIXED(MFIX)) i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_o),
    .SDA_OE(sda_oe), .STRAP_FREQ_CODE_PINS(5'h16), .PLATFORM_STRAP(plat),
    .DYN_FREQ_PINS(dyn), .WD_EXPIRE(wd), .PROC_SYNTH_N(n), .PROC_SYNTH_M(m),
    .PROC_PROG_EN(prog), .PROC_FREQ_CODE(code), .PROC_N_LOAD(load),
    .DYN_FREQ_ACTIVE(dact), .SERIAL_REF_SYNTH_N(sn), .SERIAL_REF_SYNTH_M(sm),
    .SERIAL_REF_PROG_EN(sen), .EXT_RESET_IN_EN(xen), .WD_RESET_ONLY(ronly),
    .SHARED_A_ROUTE(a_rt), .SHARED_B_ROUTE(b_rt));
  smb_host i_host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda(sda_h));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial
  begin
    forever #20 clk = ~clk;
  end
  task w(input int k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rdv);
    chk(rdv, e);
  endtask
  task pulse;
    wd = 1'b1;
    w(1);
    wd = 1'b0;
    w(3);
  endtask
  task rst(input logic [1:0] p);
    rst_n = 1'b0;
    plat = p;
    w(3);
    rst_n = 1'b1;
    w(3);
  endtask
  task results;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      results;
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      rst(i[1:0]);
      chk({a_rt, b_rt}, rt[i]);
    end
    chk({n, m, prog, dact, sen, xen}, 0);
    for (int a = 16; a < 19; a++)
      rdchk(a[7:0], 8'h00);
    rdchk(8'h20, 8'h00);
    i_host.probe(7'h11);
    chk(i_host.ack, 1'b0);
    i_host.wr(8'h0E, '{8'hA5, 8'hD3});
    chk(i_host.ack, 1'b1);
    fork
      i_host.wr(8'h12, '{8'h04});
    join_none
    w(338);
    chk(prog, 1'b0);
    wait fork;
    chk({prog, n, m}, {1'b1, 9'h1A5, 7'h53});
    i_host.wr(8'h10, '{8'h5C, 8'h3C, 8'h8D});
    chk({sen, sn, sm}, {1'b1, 9'h15C, MFIX});
    rdchk(8'h11, 8'h3C);
    rdchk(8'h12, 8'h8D);
    i_host.wr(8'h12, '{8'h50, 8'h09});
    chk({xen, code}, 6'h39);
    i_host.wr(8'h12, '{8'h00});
    chk({xen, code}, 6'h16);
    i_host.wr(8'h09, '{8'hA0, 8'h11, 8'h22, 8'h33});
    i_host.wr(8'h12, '{8'h24});
    chk(dact, 1'b1);
    for (int i = 1; i < 5; i++)
    begin
      dyn = i[1:0];
      w(1);
      chk(load, 1'b1);
      w(2);
      chk(n, dn[i % 4]);
    end
    i_host.wr(8'h12, '{8'h8E});
    i_host.wr(8'h0D, '{8'h81});
    i_host.wr(8'h0E, '{8'h10, 8'h05});
    pulse;
    chk({n, m, sn}, {9'h1A5, 7'h53, 9'h15C});
    i_host.wr(8'h12, '{8'h8D});
    i_host.wr(8'h0E, '{8'h10, 8'h05});
    pulse;
    chk({n, m}, {9'h13C, 7'h53});
    i_host.wr(8'h0D, '{8'hC1, 8'h10, 8'h05});
    pulse;
    chk({ronly, n, m}, {1'b1, 9'h010, 7'h05});
    i_host.wr(8'h0D, '{8'h01});
    pulse;
    chk(prog, 1'b0);
    rdchk(8'h12, 8'h89);
    rdchk(8'h14, 8'hB6);
    results;
  end
endmodule
`default_nettype wire
